//--- dbmi_top.v
`include "dbmi_map.vh"

module dbmi_top (
  input  wire                    clk,
  input  wire                    reset,
  input  wire                    command_timing_input,
  input  wire                    cmd_select_n,
  input  wire                    cmd_write_n,
  input  wire                    cmd_refresh_n,
  input  wire [`DBMI_BANK_W-1:0] bank_addr,
  input  wire [`DBMI_PIN_AW-1:0] addr,
  input  wire                    write_strobe_input,
  input  wire [`DBMI_DW-1:0]     write_data,
  input  wire                    write_word_mask,
  output reg                     read_clock_q,
  output reg  [`DBMI_DW-1:0]     read_data_q,
  output reg                     read_data_oe_n_q,
  output reg                     read_valid_flag_q,
  output reg                     write_ready_q,
  output reg  [1:0]              burst_length_setting_q,
  output reg  [`DBMI_BANK_W+`DBMI_ROW_W-1:0] refresh_row_q,
  output reg                     refresh_done_q
);

  // ****************************************
  // Constants
  // ****************************************
  localparam [2:0] HC_LAST = `DBMI_QCLK_HC_LAST;  // Last cycle of a half period

  // ****************************************
  // Operating notes
  // ****************************************
  // Command codes, select low, on write_n and refresh_n:
  //   00 mode write, burst code on addr[1:0]
  //   01 write burst to bank and row/column on addr
  //   10 refresh of the bank on bank_addr
  //   11 read burst from bank and row/column on addr
  // Mode code 3 is ignored, so the old burst length survives
  // Every pin passes two flops before any decode reads it
  // Pins must therefore stand three clocks around a command rise
  // The command clock is sampled, not used as a clock
  // Its rise is the only point where a command is taken
  // Write words ride both strobe edges, first word on the rise
  // Write data is synchronised in the same word as the strobe
  // That keeps data and its edge aligned after the flops
  // Words enter a two-entry buffer and drain into the array
  // Reads own the array port; the buffer waits for a free cycle
  // A word that meets a full buffer is dropped but still counted
  // Trade-off: no back pressure on the strobe, only a ready level
  // The controller must watch write_ready and pace its strobes
  // The output data clock toggles every fixed half period
  // It runs from reset on, whether or not a read is pending
  // One read word is launched on each of its edges while a burst lasts
  // Read valid and the output drive follow the same edges
  // A new read command restarts the burst at its own address
  // Columns wrap inside the eight columns of the addressed row
  // Refresh rows come from one counter per bank
  // The refresh row output shows the bank and the row just done
  // Limitation: no refresh interval is enforced in here
  // Keeping the interval is the controller's duty alone

  // Word count of a burst code
  function [3:0] bl_words;
    input [1:0] code;
    begin
      case (code)
        `DBMI_BL_CODE_4: bl_words = `DBMI_BL_WORDS_4;
        `DBMI_BL_CODE_8: bl_words = `DBMI_BL_WORDS_8;
        default:         bl_words = `DBMI_BL_WORDS_2;
      endcase
    end
  endfunction

  // Column step that wraps inside the burst's row
  function [`DBMI_AW-1:0] next_col;
    input [`DBMI_AW-1:0] a;
    begin
      next_col = {a[`DBMI_AW-1:`DBMI_COL_W], a[`DBMI_COL_W-1:0] + 3'h1};
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg  [`DBMI_SYNC_W-1:0] sync1_q;   // First stage, read only by second
  reg  [`DBMI_SYNC_W-1:0] sync2_q;   // Stable copy of all pins
  reg                     ck_prev_q; // Command clock one cycle back
  reg                     dk_prev_q; // Strobe one cycle back

  // Two flops on every pin from the controller
  always @(posedge clk) begin
    if (reset) begin
      sync1_q   <= {`DBMI_SYNC_W{1'b0}};
      sync2_q   <= {`DBMI_SYNC_W{1'b0}};
      ck_prev_q <= 1'b0;
      dk_prev_q <= 1'b0;
    end else begin
      sync1_q   <= {command_timing_input, write_strobe_input, cmd_select_n, cmd_write_n,
                    cmd_refresh_n, bank_addr, addr, write_data, write_word_mask};
      sync2_q   <= sync1_q;
      ck_prev_q <= sync2_q[24];
      dk_prev_q <= sync2_q[23];
    end
  end

  wire                    s_ck   = sync2_q[24];
  wire                    s_dk   = sync2_q[23];
  wire                    s_cs_n = sync2_q[22];
  wire                    s_we_n = sync2_q[21];
  wire                    s_rf_n = sync2_q[20];
  wire [`DBMI_BANK_W-1:0] s_bank = sync2_q[19:17];
  wire [`DBMI_PIN_AW-1:0] s_addr = sync2_q[16:10];
  wire [`DBMI_DW-1:0]     s_data = sync2_q[9:1];
  wire                    s_mask = sync2_q[0];

  wire ck_rise = s_ck & ~ck_prev_q;   // Only command sampling point
  wire dk_edge = s_dk ^ dk_prev_q;    // Either strobe edge

  // ****************************************
  // Command decode and burst control
  // ****************************************
  reg  [3:0]              wr_left_q;           // Write words still expected
  reg  [`DBMI_AW-1:0]     wr_addr_q;           // Next write location
  reg  [3:0]              rd_left_q;           // Read words still to send
  reg  [`DBMI_AW-1:0]     rd_addr_q;           // Next read location
  reg                     rd_have_q;           // Fetched word waiting for launch
  reg  [`DBMI_ROW_W-1:0]  row_ctr_q [0:7];     // Per-bank refresh rows
  reg  [2:0]              hc_q;                // Half-period counter
  integer                 i;

  wire hc_end   = (hc_q == HC_LAST);             // Output clock toggles here
  wire rd_issue = (hc_q == 3'h0) && (rd_left_q != 4'h0) && !rd_have_q;

  wire cmd_ok   = ck_rise & ~s_cs_n;
  wire cmd_mrs  = cmd_ok & ~s_we_n & ~s_rf_n;
  wire cmd_ref  = cmd_ok &  s_we_n & ~s_rf_n;
  wire cmd_wr   = cmd_ok & ~s_we_n &  s_rf_n;
  wire cmd_rd   = cmd_ok &  s_we_n &  s_rf_n;

  // Two-entry write buffer, declared here for the push term
  reg  [`DBMI_ENTRY_W-1:0] buf_q [0:1];  // Address, data, mask
  reg                      wp_q;         // Write slot
  reg                      rp_q;         // Read slot
  reg  [1:0]               cnt_q;        // Occupancy
  wire                     buf_full  = (cnt_q == 2'h2);
  wire                     buf_valid = (cnt_q != 2'h0);
  wire                     push = dk_edge && (wr_left_q != 4'h0) && !buf_full;
  wire                     pop  = buf_valid && !rd_issue;  // Reads own the port first

  // Commands, mode register, refresh rows
  always @(posedge clk) begin
    if (reset) begin
      burst_length_setting_q <= `DBMI_BL_RESET;
      wr_left_q              <= 4'h0;
      wr_addr_q              <= {`DBMI_AW{1'b0}};
      refresh_row_q          <= 7'h00;
      refresh_done_q         <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        row_ctr_q[i] <= 4'h0;
      end
    end else begin
      refresh_done_q <= cmd_ref;
      // Only legal codes change the setting; it stays until rewritten
      if (cmd_mrs && (s_addr[1:0] != 2'h3)) begin
        burst_length_setting_q <= s_addr[1:0];
      end
      // Bank picks its own counter, no row from the pins
      if (cmd_ref) begin
        refresh_row_q       <= {s_bank, row_ctr_q[s_bank]};
        row_ctr_q[s_bank]   <= row_ctr_q[s_bank] + 4'h1;
      end
      if (cmd_wr) begin
        wr_left_q <= bl_words(burst_length_setting_q);
        wr_addr_q <= {s_bank, s_addr[`DBMI_ROW_W+`DBMI_COL_W-1:0]};
      end else if (dk_edge && (wr_left_q != 4'h0)) begin
        // A word met by a full buffer is lost; write_ready warns beforehand
        wr_left_q <= wr_left_q - 4'h1;
        wr_addr_q <= next_col(wr_addr_q);
      end
    end
  end

  // ****************************************
  // Write buffer
  // ****************************************
  // Push on strobe edges, drain into the array when the port is free
  always @(posedge clk) begin
    if (reset) begin
      wp_q          <= 1'b0;
      rp_q          <= 1'b0;
      cnt_q         <= 2'h0;
      write_ready_q <= 1'b1;
      buf_q[0]      <= {`DBMI_ENTRY_W{1'b0}};
      buf_q[1]      <= {`DBMI_ENTRY_W{1'b0}};
    end else begin
      if (push) begin
        buf_q[wp_q] <= {wr_addr_q, s_data, s_mask};
        wp_q        <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      // Occupancy and ready follow the same update
      case ({push, pop})
        2'b10: begin
          cnt_q         <= cnt_q + 2'h1;
          write_ready_q <= (cnt_q == 2'h0);
        end
        2'b01: begin
          cnt_q         <= cnt_q - 2'h1;
          write_ready_q <= 1'b1;
        end
        default: begin
          write_ready_q <= !buf_full;
        end
      endcase
    end
  end

  wire [`DBMI_ENTRY_W-1:0] head = buf_q[rp_q];
  wire                     mem_we = pop && !head[0];

  // ****************************************
  // Array
  // ****************************************
  wire [`DBMI_DW-1:0] mem_rdata;  // Registered read word

  dbmi_mem u_mem (
    .clk     (clk),
    .wr_en   (mem_we),
    .rd_en   (rd_issue),
    .addr    (rd_issue ? rd_addr_q : head[`DBMI_ENTRY_W-1:`DBMI_DW+1]),
    .wdata   (head[`DBMI_DW:1]),
    .rdata_q (mem_rdata)
  );

  // ****************************************
  // Read launch on the output data clock
  // ****************************************
  // Clock toggles forever; a word rides each edge while a burst lasts
  always @(posedge clk) begin
    if (reset) begin
      hc_q              <= 3'h0;
      read_clock_q      <= 1'b0;
      read_data_q       <= {`DBMI_DW{1'b0}};
      read_data_oe_n_q  <= 1'b1;
      read_valid_flag_q <= 1'b0;
      rd_left_q         <= 4'h0;
      rd_addr_q         <= {`DBMI_AW{1'b0}};
      rd_have_q         <= 1'b0;
    end else begin
      hc_q <= hc_end ? 3'h0 : hc_q + 3'h1;
      if (hc_end) begin
        read_clock_q <= ~read_clock_q;
      end
      if (rd_issue) begin
        rd_have_q <= 1'b1;
        rd_addr_q <= next_col(rd_addr_q);
      end
      if (cmd_rd) begin
        // A new read restarts the burst at its own address
        rd_left_q <= bl_words(burst_length_setting_q);
        rd_addr_q <= {s_bank, s_addr[`DBMI_ROW_W+`DBMI_COL_W-1:0]};
        rd_have_q <= 1'b0;
      end else if (hc_end && rd_have_q) begin
        read_data_q       <= mem_rdata;
        read_valid_flag_q <= 1'b1;
        read_data_oe_n_q  <= 1'b0;
        rd_left_q         <= rd_left_q - 4'h1;
        rd_have_q         <= 1'b0;
      end
      if (hc_end && !rd_have_q) begin
        // No word for this edge: release bus, drop valid
        read_valid_flag_q <= 1'b0;
        read_data_oe_n_q  <= 1'b1;
      end
    end
  end

endmodule

//--- dbmi_map.vh
`ifndef DBMI_MAP_VH
`define DBMI_MAP_VH

// ****************************************
// Widths of the array and its pins
// ****************************************
`define DBMI_DW            9
`define DBMI_BANK_W        3
`define DBMI_ROW_W         4
`define DBMI_COL_W         3
`define DBMI_AW            10
`define DBMI_PIN_AW        7
`define DBMI_ENTRY_W       20
`define DBMI_SYNC_W        25

// ****************************************
// Burst length codes on addr[1:0] of a mode write
// ****************************************
`define DBMI_BL_CODE_2     2'h0
`define DBMI_BL_CODE_4     2'h1
`define DBMI_BL_CODE_8     2'h2
`define DBMI_BL_RESET      2'h0
`define DBMI_BL_WORDS_2    4'h2
`define DBMI_BL_WORDS_4    4'h4
`define DBMI_BL_WORDS_8    4'h8

// ****************************************
// Timing of the output data clock
// ****************************************
`define DBMI_CLK_NS        8
`define DBMI_QCLK_HALF_NS  32
`define DBMI_QCLK_HALF_CYC ((`DBMI_QCLK_HALF_NS + `DBMI_CLK_NS - 1) / `DBMI_CLK_NS)
`define DBMI_QCLK_HC_LAST  3'h3

`endif

//--- dbmi_mem.v
`include "dbmi_map.vh"

// ****************************************
// Single-port array, read data from a register
// ****************************************
module dbmi_mem (
  input  wire                 clk,
  input  wire                 wr_en,
  input  wire                 rd_en,
  input  wire [`DBMI_AW-1:0]  addr,
  input  wire [`DBMI_DW-1:0]  wdata,
  output reg  [`DBMI_DW-1:0]  rdata_q
);

  reg [`DBMI_DW-1:0] cell_q [0:(1 << `DBMI_AW)-1];  // Eight banks side by side

  // Write stores, read loads; rdata holds between reads
  always @(posedge clk) begin
    if (wr_en) begin
      cell_q[addr] <= wdata;
    end
    if (rd_en) begin
      rdata_q <= cell_q[addr];
    end
  end

endmodule

//--- dbmi_top_props.sv
`include "dbmi_map.vh"

// ******
// Read path and command checks
// ******
module dbmi_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       command_timing_input,
  input wire logic       cmd_select_n,
  input wire logic       cmd_write_n,
  input wire logic       cmd_refresh_n,
  input wire logic [2:0] bank_addr,
  input wire logic [6:0] addr,
  input wire logic       read_clock_q,
  input wire logic [8:0] read_data_q,
  input wire logic       read_data_oe_n_q,
  input wire logic       read_valid_flag_q,
  input wire logic [1:0] burst_length_setting_q,
  input wire logic [6:0] refresh_row_q,
  input wire logic       refresh_done_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins held steady while the command clock is high
  wire mode_pins = !cmd_select_n && !cmd_write_n && !cmd_refresh_n && command_timing_input;
  wire ref_pins  = !cmd_select_n && cmd_write_n && !cmd_refresh_n && command_timing_input;
  wire [1:0] code_pins = addr[1:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  qclk_period_a: assert property (
    $changed(read_clock_q) |=> $stable(read_clock_q) [*3] ##1 $changed(read_clock_q))
    else $error("output clock half period wrong");
  data_launch_a: assert property (
    $changed(read_data_q) |-> $changed(read_clock_q)) else $error("read data off clock edge");
  valid_launch_a: assert property (
    $changed(read_valid_flag_q) |-> $changed(read_clock_q)) else $error("valid off clock edge");
  valid_drive_a: assert property (
    read_valid_flag_q != read_data_oe_n_q) else $error("valid and drive disagree");
  burst_code_a: assert property (
    $changed(burst_length_setting_q) |-> $past(mode_pins) && $past(code_pins) != 2'h3
      && burst_length_setting_q == $past(code_pins)) else $error("burst code changed wrongly");
  refresh_bank_a: assert property (
    refresh_done_q |-> $past(ref_pins) && refresh_row_q[6:4] == $past(bank_addr))
    else $error("refresh without command or wrong bank");
  done_pulse_a: assert property (
    refresh_done_q |=> !refresh_done_q) else $error("refresh done too long");
  row_hold_a: assert property (
    $changed(refresh_row_q) |-> refresh_done_q) else $error("refresh row moved alone");
endmodule

bind dbmi_top dbmi_chk i_chk (.clk(clk), .reset(reset),
  .command_timing_input(command_timing_input), .cmd_select_n(cmd_select_n),
  .cmd_write_n(cmd_write_n), .cmd_refresh_n(cmd_refresh_n), .bank_addr(bank_addr),
  .addr(addr), .read_clock_q(read_clock_q), .read_data_q(read_data_q),
  .read_data_oe_n_q(read_data_oe_n_q), .read_valid_flag_q(read_valid_flag_q),
  .burst_length_setting_q(burst_length_setting_q), .refresh_row_q(refresh_row_q),
  .refresh_done_q(refresh_done_q));

//--- dbmi_ctl_model.sv
// ******
// Controller model: commands and write words
// ******
module dbmi_ctl_model (
  input  wire logic  clk,
  output logic       command_timing_input,
  output logic       cmd_select_n,
  output logic       cmd_write_n,
  output logic       cmd_refresh_n,
  output logic [2:0] bank_addr,
  output logic [6:0] addr,
  output logic       write_strobe_input,
  output logic [8:0] write_data,
  output logic       write_word_mask
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle: command clock still, not selected
  initial begin
    command_timing_input = 1'b0;
    cmd_select_n = 1'b1;
    {cmd_write_n, cmd_refresh_n, bank_addr, addr} = 12'h000;
    {write_strobe_input, write_word_mask, write_data} = 11'h000;
  end
  // One 160 ns command clock frame, pins held 10 clk either side of the rise
  task automatic command(input logic wn, input logic rn, input logic [2:0] b,
                         input logic [6:0] a);
    @(posedge clk);
    cmd_select_n <= 1'b0;
    {cmd_write_n, cmd_refresh_n, bank_addr, addr} <= {wn, rn, b, a};
    repeat (10) @(posedge clk);
    command_timing_input <= 1'b1;
    repeat (10) @(posedge clk);
    command_timing_input <= 1'b0;
    cmd_select_n <= 1'b1;
    // Released lines show the inverse, never the old value
    {cmd_write_n, cmd_refresh_n, bank_addr, addr} <= ~{wn, rn, b, a};
  endtask
  // One word per strobe edge, data settled 5 clk around it
  task automatic write_words(input int n, input logic [71:0] w, input logic [7:0] m);
    for (int i = 0; i < n; i++) begin
      write_data <= w[i*9 +: 9];
      write_word_mask <= m[i];
      repeat (5) @(posedge clk);
      write_strobe_input <= ~write_strobe_input;
      repeat (5) @(posedge clk);
    end
    write_data <= ~write_data;
  endtask
endmodule

//--- tb_top.sv
`include "dbmi_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk;
  logic       reset = 1'b1;
  wire        cti, sel_n, wr_n, ref_n, strobe, mask, qclk, oe_n, qvalid, wready, rdone;
  wire [2:0]  bank;
  wire [6:0]  addr, rrow;
  wire [8:0]  wdata, qdata;
  wire [1:0]  blcode;
  int         bad_count;
  int         n_tests;
  logic [8:0] rq[$];     // Captured read words
  logic       last_qclk; // Output clock at previous look
  dbmi_top i_dbmi_top (.clk(clk), .reset(reset), .command_timing_input(cti),
    .cmd_select_n(sel_n), .cmd_write_n(wr_n), .cmd_refresh_n(ref_n), .bank_addr(bank),
    .addr(addr), .write_strobe_input(strobe), .write_data(wdata), .write_word_mask(mask),
    .read_clock_q(qclk), .read_data_q(qdata), .read_data_oe_n_q(oe_n),
    .read_valid_flag_q(qvalid), .write_ready_q(wready), .burst_length_setting_q(blcode),
    .refresh_row_q(rrow), .refresh_done_q(rdone));
  dbmi_ctl_model u_ctl (.clk(clk), .command_timing_input(cti), .cmd_select_n(sel_n),
    .cmd_write_n(wr_n), .cmd_refresh_n(ref_n), .bank_addr(bank), .addr(addr),
    .write_strobe_input(strobe), .write_data(wdata), .write_word_mask(mask));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Take a word at each output clock edge that carries one
  always @(negedge clk) begin
    if (qclk !== last_qclk && qvalid === 1'b1) rq.push_back(qdata);
    last_qclk = qclk;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic read_back(input logic [2:0] b, input int n);
    rq.delete();
    u_ctl.command(1'b1, 1'b1, b, 7'h2D);
    repeat (60) @(posedge clk);
    check(9'(rq.size()), 9'(n));
  endtask
  // Reset state and free-running output clock
  task automatic t_reset();
    int   t;
    logic p;
    t = 0;
    @(negedge clk);
    p = qclk;
    check(9'({oe_n, qvalid, wready, rdone}), 9'h00A);
    check(9'({blcode, rrow}), 9'h000);
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      if (qclk !== p) t++;
      p = qclk;
    end
    check(9'(t), 9'(64 / `DBMI_QCLK_HALF_CYC));
    $display("test reset done");
  endtask
  // Each burst length: full write, masked overwrite, read back
  task automatic t_bursts();
    int          n;
    logic [71:0] wa;
    logic [71:0] wb;
    for (int c = 0; c < 3; c++) begin
      n = 2 << c;
      for (int i = 0; i < 8; i++) begin
        wa[i*9 +: 9] = 9'h100 + 9'(c * 16 + i);
        wb[i*9 +: 9] = 9'h080 + 9'(c * 16 + i);
      end
      u_ctl.command(1'b0, 1'b0, 3'h0, 7'(c));
      check(9'(blcode), 9'(c));
      u_ctl.command(1'b0, 1'b1, 3'(c + 1), 7'h2D);
      u_ctl.write_words(n, wa, 8'h00);
      u_ctl.command(1'b0, 1'b1, 3'(c + 1), 7'h2D);
      u_ctl.write_words(n, wb, 8'h02);
      read_back(3'(c + 1), n);
      for (int i = 0; i < n; i++) check(rq[i], i == 1 ? wa[9 +: 9] : wb[i*9 +: 9]);
    end
    // Other banks at the same row and column must not touch bank 1
    read_back(3'h1, 8);
    check(rq[0], 9'h080);
    check(rq[1], 9'h101);
    $display("test bursts done");
  endtask
  // Unused mode code and refresh rows from the internal counter
  task automatic t_refuse();
    u_ctl.command(1'b0, 1'b0, 3'h0, 7'h03);
    check(9'(blcode), 9'h002);
    u_ctl.command(1'b1, 1'b0, 3'h5, 7'h7F);
    check(9'(rrow), 9'h050);
    u_ctl.command(1'b1, 1'b0, 3'h5, 7'h7F);
    check(9'(rrow), 9'h051);
    check(9'(blcode), 9'h002);
    $display("test refuse done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bursts();
    t_refuse();
    report_and_stop();
  end
  // Watchdog, far beyond the fewer than one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule
